// >>> prpd_top.v
// Hardware reset qualifier, strap capture and shared power-down / interrupt pin control.
// Assumes a single 125 MHz clock; control writes and interrupt sources come from on-chip logic.
`timescale 1ns/1ps
`include "prpd_map.vh"

// Function
// - Reset pin low for more than 1 us (125 cycles) triggers a complete reset sequence.
// - Hardware reset returns every control bit except the address field to its default value.
// - Hardware reset re-samples and re-applies all strap inputs.
// - Shared pin acts as power-down input until configured otherwise.
// - Power-down function: pin active low, device powered down while low.
// - Interrupt function: open drain, pulled low on enabled interrupt, else released.
// - Address strap captured into control register; zero selects isolate mode.
module prpd_top #(
  parameter RST_MIN_CYC = `PRPD_RST_MIN_CYC
) (
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire RESET_PIN_N_IN,
  input wire [4:0] ADDRESS_STRAP_IN,
  input wire POWERDOWN_IRQ_PIN_IN,
  output wire POWERDOWN_IRQ_PIN_OUT,
  output wire POWERDOWN_IRQ_PIN_OE_OUT,
  input wire CTRL_WR_IN,
  input wire [7:0] CTRL_WDATA_IN,
  input wire IRQ_EVENT_IN,
  input wire IRQ_CLEAR_IN,
  output reg [7:0] TRANSCEIVER_CONTROL_REG_OUT,
  output reg SOFT_RESET_OUT,
  output reg POWER_DOWN_OUT,
  output reg ISOLATE_OUT,
  output reg IRQ_PENDING_OUT
);
  // One-hot states of the reset qualifier.
  localparam ST_RUN = 3'b001;
  localparam ST_LOW = 3'b010;
  localparam ST_INIT = 3'b100;

  // Width of the low-time counter; sixteen bits cover far more than the default minimum.
  localparam CW = 16;

  // Number of address strap pins captured by a qualified reset.
  localparam SW = `PRPD_STRAP_W;

  // Last count of a qualified low level, kept at 32 bits so that the compare never truncates.
  localparam [31:0] RST_LAST = RST_MIN_CYC - 1;

  // Synchronised pin levels.
  wire reset_pin_s;
  wire pd_pin_s;
  wire [SW-1:0] strap_s;

  // Reset qualifier state and low-time counter.
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  wire [31:0] cnt_wide;

  // Next values of the registered outputs.
  reg [7:0] ctrl_nxt;
  reg isolate_nxt;
  reg soft_reset_nxt;
  reg pending_nxt;
  reg power_down_nxt;

  // Decoded control bits.
  wire irq_mode;
  wire irq_en;
  wire in_init;

  // The reset pin is asynchronous to the system clock, so it is filtered before it is counted.
  prpd_sync3 #(.RESET_VAL(1'b1)) u_rst_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .pin_in(RESET_PIN_N_IN),
    .level_out(reset_pin_s)
  );

  prpd_sync3 #(.RESET_VAL(1'b1)) u_pd_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .pin_in(POWERDOWN_IRQ_PIN_IN),
    .level_out(pd_pin_s)
  );

  // Strap pins are board levels outside the clock domain; each bit gets its own filter.
  // The capture happens long after the pin reset is seen, so the filter lag never matters.
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi = gi + 1) begin : g_strap_sync
      prpd_sync3 #(.RESET_VAL(1'b0)) u_strap_sync (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .pin_in(ADDRESS_STRAP_IN[gi]),
        .level_out(strap_s[gi])
      );
    end
  endgenerate

  // The counter is widened on purpose for the compare against the 32-bit limit.
  assign cnt_wide = {{(32-CW){1'b0}}, cnt_r};

  // The reset process is running while the qualifier sits in its init state.
  assign in_init = (state_r == ST_INIT);

  // Pulses shorter than the minimum are ignored, so glitches on the reset pin cannot wipe state.
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_RUN: begin
        cnt_nxt = {CW{1'b0}};
        if (!reset_pin_s) begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (reset_pin_s) begin
          state_nxt = ST_RUN;
        end else if (cnt_wide >= RST_LAST) begin
          state_nxt = ST_INIT;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_INIT: begin
        if (reset_pin_s) begin
          state_nxt = ST_RUN; // Reset process completes on release of the pin.
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Qualifier registers.
  always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_RUN;
      cnt_r <= {CW{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Control register next value: defaults plus the filtered strap while the reset process runs.
  // Writes are refused during the reset process, so software cannot race the strap capture.
  always @* begin
    ctrl_nxt = TRANSCEIVER_CONTROL_REG_OUT;
    isolate_nxt = ISOLATE_OUT;
    soft_reset_nxt = 1'b0;
    if (in_init) begin
      ctrl_nxt = `PRPD_CTRL_RESET;
      ctrl_nxt[`PRPD_CTRL_ADDR_LSB +: SW] = strap_s;
      isolate_nxt = (strap_s == `PRPD_ISOLATE_ADDR);
      soft_reset_nxt = 1'b1;
    end else if (CTRL_WR_IN) begin
      // Writing address zero here does not isolate; only the strap does.
      ctrl_nxt = CTRL_WDATA_IN;
    end
  end

  // Decoded function of the shared pin and the interrupt enable.
  assign irq_mode = TRANSCEIVER_CONTROL_REG_OUT[`PRPD_CTRL_IRQ_PIN_BIT];
  assign irq_en = TRANSCEIVER_CONTROL_REG_OUT[`PRPD_CTRL_IRQ_EN_BIT];

  // Pending flag next value: a new event in the clearing cycle wins over the clear.
  // Losing an event would leave the host waiting forever, a spurious one only costs a read.
  always @* begin
    pending_nxt = IRQ_PENDING_OUT;
    if (in_init) begin
      pending_nxt = 1'b0;
    end else if (IRQ_EVENT_IN && irq_en) begin
      pending_nxt = 1'b1;
    end else if (IRQ_CLEAR_IN) begin
      pending_nxt = 1'b0;
    end
  end

  // Power-down next value: the pin only counts while it serves as an input.
  // In interrupt function the device pulls the pin itself, so reading it would power it down.
  always @* begin
    power_down_nxt = 1'b0;
    if (!irq_mode) begin
      power_down_nxt = !pd_pin_s;
    end
  end

  // Output registers; the reset branch holds only constants.
  always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TRANSCEIVER_CONTROL_REG_OUT <= `PRPD_CTRL_RESET;
      ISOLATE_OUT <= 1'b0;
      SOFT_RESET_OUT <= 1'b1;
      IRQ_PENDING_OUT <= 1'b0;
      POWER_DOWN_OUT <= 1'b0;
    end else begin
      TRANSCEIVER_CONTROL_REG_OUT <= ctrl_nxt;
      ISOLATE_OUT <= isolate_nxt;
      SOFT_RESET_OUT <= soft_reset_nxt;
      IRQ_PENDING_OUT <= pending_nxt;
      POWER_DOWN_OUT <= power_down_nxt;
    end
  end

  // A user must note that the pin high level comes only from the pull-up.
  // Release therefore takes as long as the pull-up needs to charge the line.

  // Open drain: drive low only, never high; the pullup makes the high level.
  assign POWERDOWN_IRQ_PIN_OUT = 1'b0;
  assign POWERDOWN_IRQ_PIN_OE_OUT = irq_mode && IRQ_PENDING_OUT;
endmodule

// >>> prpd_map.vh
// Constants for the reset, strap and shared power-down / interrupt pin block.
// Assumes a 125 MHz system clock; included by the design files only.
`ifndef PRPD_MAP_VH
`define PRPD_MAP_VH
`define PRPD_CLK_MHZ 125
`define PRPD_RST_MIN_NS 1000
`define PRPD_RST_MIN_CYC ((`PRPD_RST_MIN_NS * `PRPD_CLK_MHZ + 999) / 1000)
`define PRPD_STRAP_W 5
`define PRPD_CTRL_RESET 8'h00
`define PRPD_CTRL_ADDR_LSB 0
`define PRPD_CTRL_IRQ_PIN_BIT 5
`define PRPD_CTRL_IRQ_EN_BIT 6
`define PRPD_ISOLATE_ADDR 5'h00
`endif

// >>> prpd_sync3.v
// Three-stage synchroniser for a pin input with agreement filtering.
// Assumes one system clock; the pin may change at any time.
`timescale 1ns/1ps
module prpd_sync3 #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire pin_in,
  output reg level_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // The first stage feeds only the second, so metastability never reaches logic.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r; // A change counts once two stages agree.
      end
    end
  end
endmodule

// >>> prpd_host.sv
// Host model driving the hardware reset pin and the power-down request.
// Assumes the shared pin is a wire with a pull-up.
`timescale 1ns/1ps
module prpd_host (
  input wire clk_in,
  input wire oe_in,
  input wire pd_in,
  input wire [7:0] low_in,
  output wire rst_n_out,
  output wire pin_out
);
  reg [7:0] cnt_r = 8'h00;
  // Holds the reset pin low for the requested number of cycles.
  always @(posedge clk_in) cnt_r <= (low_in != 8'h00) ? low_in : cnt_r - {7'h00, cnt_r != 8'h00};
  assign rst_n_out = cnt_r == 8'h00;
  // The pull-up wins unless either party pulls low.
  assign pin_out = !(oe_in || pd_in);
endmodule

// >>> prpd_top_sva.sv
// Port assertions for the reset and shared pin block.
// Assumes a short reset count from the bench.
`timescale 1ns/1ps
module prpd_top_sva #(parameter RST_MIN_CYC = 4) (
  input wire CLK_SYS_IN, RST_N_IN, RESET_PIN_N_IN, POWERDOWN_IRQ_PIN_IN, POWERDOWN_IRQ_PIN_OUT,
  input wire POWERDOWN_IRQ_PIN_OE_OUT, IRQ_EVENT_IN, IRQ_CLEAR_IN, SOFT_RESET_OUT, POWER_DOWN_OUT,
  input wire ISOLATE_OUT, IRQ_PENDING_OUT,
  input wire [4:0] ADDRESS_STRAP_IN,
  input wire [7:0] TRANSCEIVER_CONTROL_REG_OUT
);
  wire [7:0] c = TRANSCEIVER_CONTROL_REG_OUT;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_long; $fell(RESET_PIN_N_IN) ##1 !RESET_PIN_N_IN [*8] |-> ##[1:8] SOFT_RESET_OUT; endproperty
  a_long: assert property (p_long) else $error("long reset ignored");
  property p_strap; $rose(SOFT_RESET_OUT) |-> {ISOLATE_OUT, c} == {!ADDRESS_STRAP_IN, 3'h0, ADDRESS_STRAP_IN}; endproperty
  a_strap: assert property (p_strap) else $error("strap capture wrong");
  property p_pd; (!POWERDOWN_IRQ_PIN_IN && !c[5]) [*8] |-> POWER_DOWN_OUT; endproperty
  a_pd: assert property (p_pd) else $error("no power-down");
  property p_dflt; c[5] [*8] |-> !POWER_DOWN_OUT; endproperty
  a_dflt: assert property (p_dflt) else $error("power-down in irq mode");
  property p_oe; POWERDOWN_IRQ_PIN_OE_OUT == (c[5] && IRQ_PENDING_OUT) && !POWERDOWN_IRQ_PIN_OUT; endproperty
  a_oe: assert property (p_oe) else $error("pin drive wrong");
  property p_irq; IRQ_EVENT_IN && c[6] && !SOFT_RESET_OUT && RESET_PIN_N_IN |=> IRQ_PENDING_OUT; endproperty
  a_irq: assert property (p_irq) else $error("event lost");
  property p_hold; IRQ_PENDING_OUT && !IRQ_CLEAR_IN && RESET_PIN_N_IN |=> IRQ_PENDING_OUT; endproperty
  a_hold: assert property (p_hold) else $error("pending dropped");
  property p_clr; IRQ_CLEAR_IN && !IRQ_EVENT_IN |=> !IRQ_PENDING_OUT; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
endmodule
bind prpd_top prpd_top_sva #(.RST_MIN_CYC(RST_MIN_CYC)) i_sva(.*);

// >>> prpd_top_test.sv
// Bench for the reset and shared pin block.
// Assumes the host model drives the reset pin and the shared pin.
`timescale 1ns/1ps
module prpd_top_test;
  logic CLK_SYS_IN = 0, RST_N_IN = 0, CTRL_WR_IN = 0, IRQ_EVENT_IN = 0, IRQ_CLEAR_IN = 0, pd = 0;
  logic [7:0] CTRL_WDATA_IN = 0, low = 0;
  logic [4:0] ADDRESS_STRAP_IN = 0;
  wire RESET_PIN_N_IN, POWERDOWN_IRQ_PIN_IN, POWERDOWN_IRQ_PIN_OUT, POWERDOWN_IRQ_PIN_OE_OUT;
  wire SOFT_RESET_OUT, POWER_DOWN_OUT, ISOLATE_OUT, IRQ_PENDING_OUT;
  wire [7:0] TRANSCEIVER_CONTROL_REG_OUT;
  logic [31:0] rnd = 32'hD491;
  // Linear feedback shift register step for the random strap values.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  logic [8:0] q[$];
  int bad_count = 0, n_checks = 0;
  prpd_top #(.RST_MIN_CYC(4)) i_prpd_top(.*);
  prpd_host i_prpd_host(.clk_in(CLK_SYS_IN), .oe_in(POWERDOWN_IRQ_PIN_OE_OUT), .pd_in(pd), .low_in(low),
    .rst_n_out(RESET_PIN_N_IN), .pin_out(POWERDOWN_IRQ_PIN_IN));
  initial forever #4 CLK_SYS_IN = ~CLK_SYS_IN;
  task ck(input string n, input logic [8:0] e, input logic [8:0] a);
    n_checks++;
    if (e !== a) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, a);
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge CLK_SYS_IN);
  endtask
  // A long reset pulse; the capture it should cause is queued.
  task pinrst(input logic [4:0] s);
    ADDRESS_STRAP_IN = s;
    q.push_back({s == 5'h00, 3'h0, s});
    low = 8'h14;
    cyc(1);
    low = 8'h00;
    cyc(40);
  endtask
  // Each new reset process takes the oldest queued capture.
  always @(posedge SOFT_RESET_OUT) if (RST_N_IN) begin
    cyc(1);
    ck("strap", q.pop_front(), {ISOLATE_OUT, TRANSCEIVER_CONTROL_REG_OUT});
  end
  initial begin
    cyc(8);
    RST_N_IN = 1;
    cyc(2);
    pinrst(5'h00);
    repeat (3) begin
      rnd = lfsr(rnd);
      pinrst(rnd[4:0]);
    end
    pd = 1;
    cyc(12);
    ck("pd", 9'h001, POWER_DOWN_OUT);
    CTRL_WDATA_IN = 8'h60;
    CTRL_WR_IN = 1;
    cyc(1);
    CTRL_WR_IN = 0;
    cyc(12);
    ck("pd_off", 9'h000, POWER_DOWN_OUT);
    pd = 0;
    // A two-cycle pulse is too short and must leave the register alone.
    low = 8'h02;
    cyc(1);
    low = 8'h00;
    cyc(12);
    ck("short", 9'h060, TRANSCEIVER_CONTROL_REG_OUT);
    IRQ_EVENT_IN = 1;
    cyc(1);
    IRQ_EVENT_IN = 0;
    cyc(3);
    ck("irq", 9'h003, {IRQ_PENDING_OUT, POWERDOWN_IRQ_PIN_OE_OUT});
    ck("irq_pin", 9'h000, POWERDOWN_IRQ_PIN_IN);
    IRQ_CLEAR_IN = 1;
    cyc(1);
    IRQ_CLEAR_IN = 0;
    ck("clr", 9'h000, {IRQ_PENDING_OUT, POWERDOWN_IRQ_PIN_OE_OUT});
    IRQ_EVENT_IN = 1;
    cyc(1);
    IRQ_EVENT_IN = 0;
    pinrst(5'h1F);
    ck("rst_state", 9'h000, {IRQ_PENDING_OUT, SOFT_RESET_OUT, POWER_DOWN_OUT});
    wrap_up;
  end
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
endmodule
